// ===== timer_pair.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module timer_pair
	import timer_pair_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register bus
	input wire ahb_req_t ahb_i,
	output ahb_rsp_t ahb_o,
	// Pins and CPU state
	input wire logic gate_input_pin_i,
	input wire logic ext_clk_high_i,
	input wire logic cpu_sleep_i,
	// Events
	output logic adc_trigger_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Address decode, shared by the read and the write path
	function automatic reg_sel_t reg_sel(input logic [31:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		if (addr[31:14] == 18'h00000 && addr[1:0] == 2'b00) begin
			case (addr[13:2])
				IDX_LOW_COUNT: sel = SEL_LOW_COUNT;
				IDX_UPPER_HOLD: sel = SEL_UPPER_HOLD;
				IDX_HIGH_COUNT: sel = SEL_HIGH_COUNT;
				IDX_PERIOD_LOW: sel = SEL_PERIOD_LOW;
				IDX_PERIOD_HIGH: sel = SEL_PERIOD_HIGH;
				IDX_LOW_CONTROL: sel = SEL_LOW_CONTROL;
				IDX_HIGH_CONTROL: sel = SEL_HIGH_CONTROL;
				IDX_IRQ_STATUS: sel = SEL_IRQ_STATUS;
				IDX_IRQ_MASK: sel = SEL_IRQ_MASK;
				default: sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction : reg_sel

	// Prescaler terminal count from the two-bit ratio field
	function automatic logic [7:0] ps_term(input logic [1:0] code);
		logic [7:0] t;
		t = PS_TERM_1;
		case (code)
			2'b00: t = PS_TERM_1;
			2'b01: t = PS_TERM_8;
			2'b10: t = PS_TERM_64;
			default: t = PS_TERM_256;
		endcase
		return t;
	endfunction : ps_term

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t s_r;
	state_t s_nxt;
	logic pair;
	logic lo_on;
	logic lo_src;
	logic hi_src;
	logic lo_tick;
	logic hi_tick;
	logic gate_lvl;
	logic gate_fall;
	logic match32;
	logic match_lo;
	logic match_hi;
	logic ev_high;
	logic ev_low;
	logic addr_ph;
	logic [15:0] wd;
	logic [31:0] cnt32;
	logic [31:0] inc32;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// All timer, prescaler, interrupt and bus behaviour in one pass
	always_comb begin
		s_nxt = s_r;
		wd = ahb_i.hwdata[15:0];
		// Two flops before any logic reads the pins; stage 0 feeds stage 1 only
		s_nxt.gate_sync = {s_r.gate_sync[1:0], gate_input_pin_i};
		s_nxt.ext_sync = {s_r.ext_sync[1:0], ext_clk_high_i};
		gate_lvl = s_r.gate_sync[1];
		pair = s_r.con_lo[CON_PAIR_BIT];
		lo_on = s_r.con_lo[CON_ON_BIT];

		// Lower clock source: gate level, gate pin rising edge or every cycle
		lo_src = 1'b0;
		if (lo_on && !cpu_sleep_i) begin
			if (s_r.con_lo[CON_GATE_BIT] && !s_r.con_lo[CON_CS_BIT]) begin
				lo_src = gate_lvl;
			end else if (s_r.con_lo[CON_CS_BIT]) begin
				lo_src = s_r.gate_sync[1] && !s_r.gate_sync[2];
			end else begin
				lo_src = 1'b1;
			end
		end
		// Upper source never gated; idle in pair mode since its control is ignored
		hi_src = 1'b0;
		if (!pair && s_r.con_hi[CON_ON_BIT] && !cpu_sleep_i) begin
			hi_src = s_r.con_hi[CON_CS_BIT] ? (s_r.ext_sync[1] && !s_r.ext_sync[2]) : 1'b1;
		end

		// Prescalers divide the source into count ticks
		lo_tick = lo_src && (s_r.ps_lo == ps_term(s_r.con_lo[CON_PS_LSB +: 2]));
		hi_tick = hi_src && (s_r.ps_hi == ps_term(s_r.con_hi[CON_PS_LSB +: 2]));
		if (lo_src) begin
			s_nxt.ps_lo = lo_tick ? 8'h00 : s_r.ps_lo + 8'h01;
		end
		if (hi_src) begin
			s_nxt.ps_hi = hi_tick ? 8'h00 : s_r.ps_hi + 8'h01;
		end

		// Falling gate ends accumulation; the count is simply left alone
		gate_fall = lo_on && s_r.con_lo[CON_GATE_BIT] && !s_r.con_lo[CON_CS_BIT] &&
			!s_r.gate_sync[1] && s_r.gate_sync[2];

		// Counters: one 32-bit pair or two independent halves
		cnt32 = {s_r.tmr_hi, s_r.tmr_lo};
		inc32 = cnt32 + 32'h0000_0001;
		match32 = 1'b0;
		match_lo = 1'b0;
		match_hi = 1'b0;
		if (pair) begin
			match32 = lo_tick && (cnt32 == {s_r.pr_hi, s_r.pr_lo});
			if (lo_tick) begin
				{s_nxt.tmr_hi, s_nxt.tmr_lo} = match32 ? 32'h0000_0000 : inc32;
			end
		end else begin
			match_lo = lo_tick && (s_r.tmr_lo == s_r.pr_lo);
			match_hi = hi_tick && (s_r.tmr_hi == s_r.pr_hi);
			if (lo_tick) begin
				s_nxt.tmr_lo = match_lo ? 16'h0000 : s_r.tmr_lo + 16'h0001;
			end
			if (hi_tick) begin
				s_nxt.tmr_hi = match_hi ? 16'h0000 : s_r.tmr_hi + 16'h0001;
			end
		end

		// Events: upper flag owns the pair; lower flag serves the lone lower timer
		ev_high = pair ? (match32 || gate_fall) : match_hi;
		ev_low = !pair && (match_lo || gate_fall);
		s_nxt.adc_trig = pair ? match32 : match_hi;
		s_nxt.status = s_r.status;
		s_nxt.status[IRQ_HIGH_BIT] = s_r.status[IRQ_HIGH_BIT] | ev_high;
		s_nxt.status[IRQ_LOW_BIT] = s_r.status[IRQ_LOW_BIT] | ev_low;
		// One cycle later than the flag, so the pin is a clean flop
		s_nxt.irq = |(s_r.status & s_r.mask);

		// Address phase: capture the target; reads are answered from a flop
		addr_ph = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
		s_nxt.dp_wr = addr_ph && ahb_i.hwrite;
		s_nxt.dp_sel = addr_ph ? reg_sel(ahb_i.haddr) : SEL_NONE;
		s_nxt.rsp.hreadyout = 1'b1;
		s_nxt.rsp.hresp = 1'b0;
		if (addr_ph && !ahb_i.hwrite) begin
			s_nxt.rsp.hrdata = 32'h0000_0000;
			case (reg_sel(ahb_i.haddr))
				SEL_LOW_COUNT: begin
					s_nxt.rsp.hrdata[15:0] = s_r.tmr_lo;
					s_nxt.hold = s_r.tmr_hi;
				end
				SEL_UPPER_HOLD: s_nxt.rsp.hrdata[15:0] = s_r.hold;
				SEL_HIGH_COUNT: s_nxt.rsp.hrdata[15:0] = s_r.tmr_hi;
				SEL_PERIOD_LOW: s_nxt.rsp.hrdata[15:0] = s_r.pr_lo;
				SEL_PERIOD_HIGH: s_nxt.rsp.hrdata[15:0] = s_r.pr_hi;
				SEL_LOW_CONTROL: s_nxt.rsp.hrdata[15:0] = s_r.con_lo;
				SEL_HIGH_CONTROL: s_nxt.rsp.hrdata[15:0] = s_r.con_hi;
				SEL_IRQ_STATUS: s_nxt.rsp.hrdata[IRQ_W-1:0] = s_r.status;
				SEL_IRQ_MASK: s_nxt.rsp.hrdata[IRQ_W-1:0] = s_r.mask;
				default: s_nxt.rsp.hrdata = 32'h0000_0000;
			endcase
		end

		// Data phase write: overrides the count update of the same cycle
		if (s_r.dp_wr) begin
			case (s_r.dp_sel)
				SEL_LOW_COUNT: begin
					s_nxt.tmr_lo = wd;
					if (pair) begin
						s_nxt.tmr_hi = s_r.hold;
					end
					if (lo_on) begin
						s_nxt.ps_lo = 8'h00;
					end
				end
				SEL_UPPER_HOLD: s_nxt.hold = wd;
				SEL_HIGH_COUNT: begin
					s_nxt.tmr_hi = wd;
					s_nxt.ps_hi = 8'h00;
					if (pair && lo_on) begin
						s_nxt.ps_lo = 8'h00;
					end
				end
				SEL_PERIOD_LOW: s_nxt.pr_lo = wd;
				SEL_PERIOD_HIGH: s_nxt.pr_hi = wd;
				SEL_LOW_CONTROL: begin
					// Counts untouched here
					s_nxt.con_lo = wd & CON_LOW_WMASK;
					if (lo_on) begin
						s_nxt.ps_lo = 8'h00;
					end
				end
				SEL_HIGH_CONTROL: begin
					s_nxt.con_hi = wd & CON_HIGH_WMASK;
					s_nxt.ps_hi = 8'h00;
				end
				SEL_IRQ_STATUS: begin
					// Write one to clear; a new event in the same cycle wins
					s_nxt.status = (s_r.status & ~wd[IRQ_W-1:0]) | {ev_low, ev_high};
				end
				SEL_IRQ_MASK: s_nxt.mask = wd[IRQ_W-1:0];
				default: s_nxt.mask = s_r.mask;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Reset clears prescalers and control as a device reset must
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state flops
	assign ahb_o = s_r.rsp;
	assign adc_trigger_o = s_r.adc_trig;
	assign irq_o = s_r.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	gate_low_hold_a: assert property (
		(pair && lo_on && s_r.con_lo[CON_GATE_BIT] && !s_r.con_lo[CON_CS_BIT] &&
		!gate_lvl && !s_r.dp_wr) |=> (cnt32 == $past(cnt32)))
		else $error("gated pair counted with gate low");

	sleep_stop_a: assert property (
		(cpu_sleep_i && !s_r.dp_wr) |=> ($stable(s_r.tmr_lo) && $stable(s_r.tmr_hi)))
		else $error("timer counted during sleep");

	pair_wrap_a: assert property (
		(pair && lo_tick && cnt32 == {s_r.pr_hi, s_r.pr_lo} && !s_r.dp_wr) |=>
		(cnt32 == 32'h0000_0000))
		else $error("pair did not wrap to zero at period");

	adc_pulse_a: assert property (
		adc_trigger_o |-> $past(pair ? match32 : match_hi))
		else $error("converter trigger without match");

	flag_set_a: assert property (
		ev_high |=> s_r.status[IRQ_HIGH_BIT] ##1
		(irq_o || !$past(s_r.mask[IRQ_HIGH_BIT])))
		else $error("upper flag missed an event");

	flag_sticky_a: assert property (
		(s_r.status[IRQ_HIGH_BIT] && !(s_r.dp_wr && s_r.dp_sel == SEL_IRQ_STATUS)) |=> s_r.status[IRQ_HIGH_BIT])
		else $error("flag cleared without a software write");

	irq_gate_a: assert property (
		##1 (irq_o == $past(|(s_r.status & s_r.mask))))
		else $error("interrupt output does not follow flag and enable");

	hold_latch_a: assert property (
		(addr_ph && !ahb_i.hwrite && reg_sel(ahb_i.haddr) == SEL_LOW_COUNT) |=>
		(s_r.hold == $past(s_r.tmr_hi)))
		else $error("lower count read did not latch upper half");

	coherent_wr_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_COUNT && pair) |=> (s_r.tmr_hi == $past(s_r.hold)))
		else $error("lower write did not load held upper half");

	ps_clear_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_COUNT && lo_on) |=> (s_r.ps_lo == 8'h00))
		else $error("count write did not clear prescaler");

	ps_off_keep_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_COUNT && !lo_on) |=> $stable(s_r.ps_lo))
		else $error("prescaler cleared while timer off");

	con_keep_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_HIGH_CONTROL && !lo_tick && !hi_tick) |=>
		($stable(s_r.tmr_lo) && $stable(s_r.tmr_hi)))
		else $error("control write changed a count");

	ctl_lo_keep_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_CONTROL && !lo_tick && !hi_tick) |=>
		($stable(s_r.tmr_lo) && $stable(s_r.tmr_hi)))
		else $error("low control write changed a count");

	// Match and gate events; writes are left out of the count check only, since they override the count
	adc_match_a: assert property (
		(pair ? (lo_tick && cnt32 == {s_r.pr_hi, s_r.pr_lo}) :
		(hi_tick && s_r.tmr_hi == s_r.pr_hi)) |=> adc_trigger_o)
		else $error("period match gave no converter trigger");

	gate_fall_flag_a: assert property (
		(pair && lo_on && s_r.con_lo[CON_GATE_BIT] && !s_r.con_lo[CON_CS_BIT] &&
		s_r.gate_sync[2] && !s_r.gate_sync[1]) |=> s_r.status[IRQ_HIGH_BIT])
		else $error("gate falling edge did not set the flag");

	gate_fall_keep_a: assert property (
		(pair && lo_on && s_r.con_lo[CON_GATE_BIT] && !s_r.con_lo[CON_CS_BIT] &&
		s_r.gate_sync[2] && !s_r.gate_sync[1] && !s_r.dp_wr) |=>
		(cnt32 == $past(cnt32)))
		else $error("gate falling edge changed the count");

	// Upper half ignores its gate enable, and all of its control in pair mode
	upper_ungated_a: assert property (
		(!pair && s_r.con_hi[CON_ON_BIT] && !s_r.con_hi[CON_CS_BIT] && !cpu_sleep_i &&
		s_r.con_hi[CON_PS_LSB +: 2] == 2'b00 && s_r.ps_hi == 8'h00 &&
		s_r.tmr_hi != s_r.pr_hi && !s_r.dp_wr) |=>
		(s_r.tmr_hi == $past(s_r.tmr_hi) + 16'h0001))
		else $error("upper timer did not count every cycle");

	pair_upper_idle_a: assert property (
		(pair && !s_r.dp_wr) |=> $stable(s_r.ps_hi))
		else $error("upper prescaler ran in pair mode");

	pair_upper_still_a: assert property (
		(pair && !lo_tick && !s_r.dp_wr) |=> $stable(s_r.tmr_hi))
		else $error("upper half moved without a pair tick");

	pair_carry_a: assert property (
		(pair && lo_tick && cnt32 != {s_r.pr_hi, s_r.pr_lo} && !s_r.dp_wr) |=>
		(cnt32 == $past(cnt32) + 32'h0000_0001))
		else $error("pair did not count as one 32-bit value");

	// Prescaler stepping, clearing and freezing
	ps_step_a: assert property (
		(lo_src && s_r.ps_lo != ps_term(s_r.con_lo[CON_PS_LSB +: 2]) && !s_r.dp_wr) |=>
		($stable(s_r.tmr_lo) && s_r.ps_lo == $past(s_r.ps_lo) + 8'h01))
		else $error("count moved between prescaler terminal counts");

	sleep_ps_a: assert property (
		(cpu_sleep_i && !s_r.dp_wr) |=> ($stable(s_r.ps_lo) && $stable(s_r.ps_hi)))
		else $error("prescaler ran during sleep");

	ctl_ps_clear_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_HIGH_CONTROL) |=> (s_r.ps_hi == 8'h00))
		else $error("control write did not clear prescaler");

	ctl_off_keep_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_CONTROL && !lo_on) |=> $stable(s_r.ps_lo))
		else $error("prescaler cleared by control write while off");

	split_write_a: assert property (
		(s_r.dp_wr && s_r.dp_sel == SEL_LOW_COUNT && !pair && !hi_tick) |=>
		$stable(s_r.tmr_hi))
		else $error("lower write touched upper count in 16-bit mode");

endmodule : timer_pair
`default_nettype wire

// ===== timer_pair_pkg.sv
`default_nettype none
package timer_pair_pkg;

	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 200_000_000;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_LOW_COUNT = 12'h106;
	localparam logic [11:0] IDX_UPPER_HOLD = 12'h108;
	localparam logic [11:0] IDX_HIGH_COUNT = 12'h10A;
	localparam logic [11:0] IDX_PERIOD_LOW = 12'h10C;
	localparam logic [11:0] IDX_PERIOD_HIGH = 12'h10E;
	localparam logic [11:0] IDX_LOW_CONTROL = 12'h110;
	localparam logic [11:0] IDX_HIGH_CONTROL = 12'h112;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h114;
	localparam logic [11:0] IDX_IRQ_MASK = 12'h116;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned CON_ON_BIT = 15;
	localparam int unsigned CON_IDLE_BIT = 13;
	localparam int unsigned CON_GATE_BIT = 6;
	localparam int unsigned CON_PS_LSB = 4;
	localparam int unsigned CON_PAIR_BIT = 3;
	localparam int unsigned CON_CS_BIT = 1;
	localparam logic [15:0] CON_LOW_WMASK = 16'hA07A;
	localparam logic [15:0] CON_HIGH_WMASK = 16'hA072;

	// ----------------------------------------------------------------
	// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
	// ----------------------------------------------------------------
	localparam logic [7:0] PS_TERM_1 = 8'h00;
	localparam logic [7:0] PS_TERM_8 = 8'h07;
	localparam logic [7:0] PS_TERM_64 = 8'h3F;
	localparam logic [7:0] PS_TERM_256 = 8'hFF;

	// ----------------------------------------------------------------
	// Interrupt status and mask bits
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_HIGH_BIT = 0;
	localparam int unsigned IRQ_LOW_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] CON_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_LOW_COUNT = 4'h1,
		SEL_UPPER_HOLD = 4'h2,
		SEL_HIGH_COUNT = 4'h3,
		SEL_PERIOD_LOW = 4'h4,
		SEL_PERIOD_HIGH = 4'h5,
		SEL_LOW_CONTROL = 4'h6,
		SEL_HIGH_CONTROL = 4'h7,
		SEL_IRQ_STATUS = 4'h8,
		SEL_IRQ_MASK = 4'h9
	} reg_sel_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_t;

	typedef struct packed {
		logic [15:0] tmr_lo;
		logic [15:0] tmr_hi;
		logic [15:0] hold;
		logic [15:0] pr_lo;
		logic [15:0] pr_hi;
		logic [15:0] con_lo;
		logic [15:0] con_hi;
		logic [7:0] ps_lo;
		logic [7:0] ps_hi;
		logic [2:0] gate_sync;
		logic [2:0] ext_sync;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic dp_wr;
		reg_sel_t dp_sel;
		ahb_rsp_t rsp;
		logic adc_trig;
		logic irq;
	} state_t;

	localparam state_t STATE_RST = '{
		tmr_lo: COUNT_RST, tmr_hi: COUNT_RST, hold: COUNT_RST,
		pr_lo: PERIOD_RST, pr_hi: PERIOD_RST,
		con_lo: CON_RST, con_hi: CON_RST,
		ps_lo: 8'h00, ps_hi: 8'h00,
		gate_sync: 3'h0, ext_sync: 3'h0,
		status: 2'h0, mask: 2'h0,
		dp_wr: 1'b0, dp_sel: SEL_NONE,
		rsp: '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0},
		adc_trig: 1'b0, irq: 1'b0
	};

endpackage : timer_pair_pkg
`default_nettype wire

// ===== gate_src.sv
`timescale 1ns/1ps
`default_nettype none
// Gate pin and external clock on the timer's pin side
module gate_src (
	// Clock
	input wire logic clk_i,
	// Commands from the bench
	input wire logic gate_req_i,
	input wire logic ext_run_i,
	// Pins
	output logic gate_o,
	output logic ext_clk_o
);
	logic gate_r = 1'h0;
	logic ext_r = 1'h0;
	logic [1:0] ph_r = 2'h0;
	// Clock toggles every third cycle; it parks low when stopped so no stray edge is seen
	always_ff @(posedge clk_i) begin
		gate_r <= gate_req_i;
		ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
		if (ph_r == 2'h2)
			ext_r <= ext_run_i & ~ext_r;
	end
	assign gate_o = gate_r;
	assign ext_clk_o = ext_r;
endmodule : gate_src
`default_nettype wire

// ===== dual_16_or_32bit_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_16_or_32bit_timer_bench import timer_pair_pkg::*;;
	// ----------
	// Signals
	// ----------
	typedef struct {logic [11:0] idx; logic w; logic [15:0] d; logic [31:0] e;} reg_row_t;
	typedef struct {logic [15:0] lo; logic [15:0] hi; logic [15:0] prh; int n;} run_row_t;
	logic clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic sleep = 1'h0;
	logic gate_req = 1'h0;
	logic ext_run = 1'h0;
	logic gate_pin;
	logic ext_clk;
	logic adc;
	logic irq;
	ahb_req_t req;
	ahb_rsp_t rsp;
	int error_cnt = 0;
	int checks_done = 0;
	reg_row_t regs [14] = '{
		'{IDX_PERIOD_LOW, 1'h0, 16'h0, 32'hFFFF}, '{IDX_PERIOD_HIGH, 1'h0, 16'h0, 32'hFFFF},
		'{IDX_LOW_CONTROL, 1'h0, 16'h0, 32'h0}, '{IDX_HIGH_CONTROL, 1'h0, 16'h0, 32'h0},
		'{IDX_IRQ_MASK, 1'h0, 16'h0, 32'h0}, '{IDX_IRQ_STATUS, 1'h0, 16'h0, 32'h0},
		'{IDX_LOW_CONTROL, 1'h1, 16'hFFFF, 32'hA07A}, '{IDX_LOW_CONTROL, 1'h1, 16'h0, 32'h0},
		'{IDX_HIGH_CONTROL, 1'h1, 16'hFFFF, 32'hA072}, '{IDX_HIGH_CONTROL, 1'h1, 16'h0, 32'h0},
		'{IDX_PERIOD_LOW, 1'h1, 16'h1234, 32'h1234}, '{IDX_UPPER_HOLD, 1'h1, 16'h5A5A, 32'h5A5A},
		'{12'h120, 1'h1, 16'hBEEF, 32'h0}, '{IDX_IRQ_MASK, 1'h1, 16'h3, 32'h3}};
	// Match spacing is (period+1) times prescale, six times that for the external clock row; pair rows must ignore the upper control
	run_row_t runs [7] = '{
		'{16'h0, 16'h8040, 16'h3, 4}, '{16'h0, 16'h8010, 16'h3, 32},
		'{16'h0, 16'h8020, 16'h3, 256}, '{16'h0, 16'h8030, 16'h3, 1024},
		'{16'h0, 16'h8002, 16'h3, 24}, '{16'h8008, 16'h8030, 16'h0, 4},
		'{16'h8018, 16'h8030, 16'h0, 32}};
	assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
		hwdata: hwdata, hready: rsp.hreadyout};
	// ----------
	// Design and pin source
	// ----------
	timer_pair dut (.clk_i(clk_i), .resetn_i(resetn_i), .ahb_i(req), .ahb_o(rsp),
		.gate_input_pin_i(gate_pin), .ext_clk_high_i(ext_clk), .cpu_sleep_i(sleep),
		.adc_trigger_o(adc), .irq_o(irq));
	gate_src src (.clk_i(clk_i), .gate_req_i(gate_req), .ext_run_i(ext_run),
		.gate_o(gate_pin), .ext_clk_o(ext_clk));
	// Clock, 5 ns period
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	// ----------
	// Tasks
	// ----------
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	// Bounded wait for hready; a hung bus ends the run
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk_i);
		while (rsp.hreadyout !== 1'h1 && n < 64) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 64) begin
			error_cnt++;
			finish_test();
		end
	endtask : wait_rdy
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d,
		output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {18'h0, idx, 2'h0};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		wait_rdy();
		rd = rsp.hrdata;
	endtask : bus
	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		logic [31:0] x;
		bus(1'h1, idx, d, x);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [11:0] idx, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, idx, 16'h0, x);
		check(nm, x, e);
	endtask : rd_chk
	// Cycles until the next converter trigger, bounded
	task automatic next_pulse(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (adc !== 1'h1 && n < 5000);
		if (n >= 5000) begin
			error_cnt++;
			finish_test();
		end
	endtask : next_pulse
	// ----------
	// Sequence
	// ----------
	initial begin
		int n;
		logic [31:0] a;
		logic [31:0] b;
		cyc(8);
		resetn_i <= 1'h1;
		foreach (regs[i]) begin
			if (regs[i].w)
				wr(regs[i].idx, regs[i].d);
			rd_chk("register", regs[i].idx, regs[i].e);
		end
		// Stop both halves and restart from zero before each spacing measurement
		wr(IDX_PERIOD_LOW, 16'h0003);
		foreach (runs[i]) begin
			wr(IDX_LOW_CONTROL, 16'h0);
			wr(IDX_HIGH_CONTROL, 16'h0);
			wr(IDX_LOW_COUNT, 16'h0);
			wr(IDX_HIGH_COUNT, 16'h0);
			wr(IDX_PERIOD_HIGH, runs[i].prh);
			ext_run <= runs[i].hi[1];
			wr(IDX_LOW_CONTROL, runs[i].lo);
			wr(IDX_HIGH_CONTROL, runs[i].hi);
			next_pulse(n);
			next_pulse(n);
			check("match_spacing", n, runs[i].n);
		end
		// Flag, mask and software clear
		wr(IDX_LOW_CONTROL, 16'h0);
		wr(IDX_HIGH_CONTROL, 16'h0);
		ext_run <= 1'h0;
		wr(IDX_IRQ_STATUS, 16'h3);
		rd_chk("status_clr", IDX_IRQ_STATUS, 32'h0);
		wr(IDX_IRQ_MASK, 16'h1);
		wr(IDX_PERIOD_HIGH, 16'h3);
		wr(IDX_HIGH_CONTROL, 16'h8000);
		next_pulse(n);
		wr(IDX_HIGH_CONTROL, 16'h0);
		cyc(20);
		check("irq_on", irq, 32'h1);
		rd_chk("flag_kept", IDX_IRQ_STATUS, 32'h1);
		wr(IDX_IRQ_MASK, 16'h0);
		cyc(3);
		check("irq_masked", irq, 32'h0);
		wr(IDX_IRQ_MASK, 16'h1);
		cyc(3);
		check("irq_unmasked", irq, 32'h1);
		wr(IDX_IRQ_STATUS, 16'h1);
		cyc(3);
		check("irq_cleared", irq, 32'h0);
		// Gated accumulation in pair mode: twenty gate-high cycles
		wr(IDX_PERIOD_LOW, 16'hFFFF);
		wr(IDX_PERIOD_HIGH, 16'hFFFF);
		wr(IDX_LOW_CONTROL, 16'h0008);
		wr(IDX_UPPER_HOLD, 16'h0);
		wr(IDX_LOW_COUNT, 16'h0);
		// Hold differs from the upper count, so a missed latch shows on readback
		wr(IDX_UPPER_HOLD, 16'h5A5A);
		wr(IDX_HIGH_CONTROL, 16'h0040);
		wr(IDX_LOW_CONTROL, 16'h8048);
		gate_req <= 1'h1;
		cyc(20);
		gate_req <= 1'h0;
		cyc(10);
		rd_chk("gated_count", IDX_LOW_COUNT, 32'h14);
		rd_chk("hold_latch", IDX_UPPER_HOLD, 32'h0);
		rd_chk("gate_fall_flag", IDX_IRQ_STATUS, 32'h1);
		cyc(10);
		rd_chk("count_held", IDX_LOW_COUNT, 32'h14);
		// Sleep freezes the count; a control write keeps it
		wr(IDX_LOW_CONTROL, 16'h0);
		wr(IDX_HIGH_CONTROL, 16'h8000);
		// Let the count leave zero so a clearing control write would show
		cyc(5);
		sleep <= 1'h1;
		bus(1'h0, IDX_HIGH_COUNT, 16'h0, a);
		wr(IDX_HIGH_CONTROL, 16'h8000);
		bus(1'h0, IDX_HIGH_COUNT, 16'h0, b);
		check("sleep_hold", b, a);
		sleep <= 1'h0;
		cyc(5);
		bus(1'h0, IDX_HIGH_COUNT, 16'h0, b);
		check("wake_counts", {31'h0, b > a}, 32'h1);
		// Reset in mid-run with the interrupt pending
		resetn_i <= 1'h0;
		cyc(2);
		check("rst_irq", irq, 32'h0);
		check("rst_trig", adc, 32'h0);
		check("rst_ready", rsp.hreadyout, 32'h1);
		check("rst_resp", rsp.hresp, 32'h0);
		resetn_i <= 1'h1;
		rd_chk("rst_period", IDX_PERIOD_LOW, 32'hFFFF);
		finish_test();
	end
endmodule : dual_16_or_32bit_timer_bench
`default_nettype wire
